/* design/hcl_pkg.sv */
// Constants, register map and state layout of the Hall commutation logic.
// Assumes one 250 MHz clock and a 16-bit register port with byte addresses.
//
// Behaviour
// R01: Edge signal on any position input change.
// R02: Software sets all channel modes to Hall code.
// R03: Edge reloads dead-time counter, starts counting.
// R04: Counter at one raises compare-ready sampling.
// R05: Sample equal current pattern means noise only.
// R06: Sample equal expected pattern pulses correct event.
// R07: Neither pattern matches pulses wrong event.
// R08: Hall mode: channel 0 captures, 1-2 compare.
// R09: Correct event copies compare shadows to active.
// R10: Correct event captures count, then resets timer.
// R11: Correct event also loads period from shadow.
// R12: No timer shadow transfer; stopped write updates both.
// R13: Channel 1 match triggers pattern transfer if selected.
// R14: Channel 2 match gives time-out interrupt event.
// R15: Software clears timer modulation enables in Hall mode.
// R16: Correct event or software sets correct flag; irq.
// R17: Correct flag clears only by software clear.
// R18: Wrong flag handled like correct flag.
// R19: Pattern transfer sets transfer flag, same handling.
// R20: Every set event requests interrupt, no re-arm; the code masks the idle set event out.
// R21: Idle set by wrong event if enabled, or software.
// R22: Idle holds output pattern cleared.
// R23: Software clears idle then requests both transfers.
// R24: Hall request bit copies written patterns immediately.
// R25: Two-flop synchroniser on each position input.
package hcl_pkg;

  // ********************************
  // Register map (byte addresses)
  // ********************************
  localparam logic [7:0] HCL_MODE_OFS    = 8'h00;
  localparam logic [7:0] HCL_CTRL_OFS    = 8'h02;
  localparam logic [7:0] HCL_DTREL_OFS   = 8'h04;
  localparam logic [7:0] HCL_PERIOD_OFS  = 8'h06;
  localparam logic [7:0] HCL_CMP1_OFS    = 8'h08;
  localparam logic [7:0] HCL_CMP2_OFS    = 8'h0A;
  localparam logic [7:0] HCL_CAPT_OFS    = 8'h0C;
  localparam logic [7:0] HCL_COUNT_OFS   = 8'h0E;
  localparam logic [7:0] HCL_PATSH_OFS   = 8'h10;
  localparam logic [7:0] HCL_PATACT_OFS  = 8'h12;
  localparam logic [7:0] HCL_STAT_OFS    = 8'h14;
  localparam logic [7:0] HCL_STSET_OFS   = 8'h16;
  localparam logic [7:0] HCL_STCLR_OFS   = 8'h18;
  localparam logic [7:0] HCL_IEN_OFS     = 8'h1A;
  localparam logic [7:0] HCL_PASSIVE_OFS = 8'h1C;

  // ********************************
  // Fields
  // ********************************
  localparam logic [3:0] HCL_HALL_MODE = 4'h8;
  localparam int HCL_CTRL_RUN    = 0;
  localparam int HCL_CTRL_IDLEEN = 1;
  localparam int HCL_CTRL_SWITCH_ENABLE_SELECT   = 2;
  localparam int HCL_PAT_HALLREQ = 15;
  localparam int HCL_PAT_CURRENT_HALL_PATTERN    = 11;
  localparam int HCL_PAT_EXPECTED_HALL_PATTERN    = 8;
  localparam int HCL_PAT_MCMREQ  = 7;
  localparam int HCL_F_CHE  = 0;
  localparam int HCL_F_WHE  = 1;
  localparam int HCL_F_STR  = 2;
  localparam int HCL_F_IDLE = 3;
  localparam int HCL_F_TMO  = 4;
  localparam logic [4:0] HCL_IRQ_MASK = 5'h17;
  localparam logic [1:0] HCL_SW_NONE  = 2'h0;
  localparam logic [1:0] HCL_SW_CHE   = 2'h1;
  localparam logic [1:0] HCL_SW_CMP1  = 2'h2;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [11:0] HCL_MODE_RST  = 12'h000;
  localparam logic [7:0]  HCL_DTREL_RST = 8'h01;
  localparam logic [15:0] HCL_WORD_RST  = 16'h0000;

  typedef struct packed {
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [2:0]  prev;
    logic [7:0]  dtc;
    logic [11:0] mode;
    logic        run;
    logic        idle_en;
    logic [1:0]  switch_enable_select;
    logic [7:0]  dt_rel;
    logic [15:0] per_sh;
    logic [15:0] per;
    logic [15:0] cmp1_sh;
    logic [15:0] cmp1;
    logic [15:0] cmp2_sh;
    logic [15:0] cmp2;
    logic [15:0] cap;
    logic [15:0] cnt;
    logic [2:0]  curhs;
    logic [2:0]  exphs;
    logic [2:0]  current_hall_pattern;
    logic [2:0]  expected_hall_pattern;
    logic [5:0]  mcmps;
    logic [5:0]  multichannel_output_pattern;
    logic [5:0]  psl_sh;
    logic [5:0]  psl;
    logic [4:0]  flags;
    logic [4:0]  interrupt_enable_register;
    logic        che_p;
    logic        whe_p;
    logic        irq;
    logic [15:0] rdata;
  } hcl_state_s;

endpackage

/* design/hcl_hall_logic.sv */
// Hall sensor commutation logic: edge filter, pattern compare, timer, flags.
// Assumes position inputs are asynchronous; register port strobes are one cycle.
`timescale 1ns/10ps
module hcl_hall_logic
  import hcl_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // Position sensors
  input  wire logic [2:0]  i_hall_position_input,
  // Pattern and events
  output logic      [5:0]  o_multichannel_output_pattern,
  output logic      [5:0]  o_passive_level_bits,
  output logic             o_correct_hall_event,
  output logic             o_wrong_hall_event,
  output logic             o_irq
);

  hcl_state_s q;
  hcl_state_s d;

  logic        edge_det;
  logic        ready;
  logic        hall;
  logic        correct_event_flag;
  logic        wrong_event_flag;
  logic        match1;
  logic        match2;
  logic        period_hit;
  logic        multichannel_shadow_transfer;
  logic        wr_ok;
  logic [4:0]  sw_set;
  logic [4:0]  sw_clr;
  logic [4:0]  hw_set;

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    d      = q;
    wr_ok  = i_wr;
    sw_set = 5'h00;
    sw_clr = 5'h00;

    // Synchroniser, first flop is read only by the second
    d.sync1 = i_hall_position_input; // [R25]
    d.sync2 = q.sync1;               // [R25]
    d.prev  = q.sync2;

    edge_det = |(q.sync2 ^ q.prev); // [R01]
    // A fresh edge restarts the delay, so it also masks the pending sample
    ready    = (q.dtc == 8'h01) && !edge_det; // [R04]
    if (edge_det) begin
      d.dtc = q.dt_rel; // [R03]
    end else if (q.dtc != 8'h00) begin
      d.dtc = q.dtc - 8'h01; // [R03]
    end

    // Current pattern checked first: a spike that settled back is ignored
    correct_event_flag = ready && (q.sync2 != q.current_hall_pattern) && (q.sync2 == q.expected_hall_pattern); // [R05] [R06]
    wrong_event_flag = ready && (q.sync2 != q.current_hall_pattern) && (q.sync2 != q.expected_hall_pattern); // [R07]
    d.che_p = correct_event_flag;
    d.whe_p = wrong_event_flag;

    hall = (q.mode[3:0] == HCL_HALL_MODE) && (q.mode[7:4] == HCL_HALL_MODE)
        && (q.mode[11:8] == HCL_HALL_MODE); // [R08]
    match1     = hall && q.run && (q.cnt == q.cmp1);
    match2     = hall && q.run && (q.cnt == q.cmp2); // [R14]
    period_hit = q.run && (q.cnt == q.per);

    // ********************************
    // Primary timer
    // ********************************
    if (q.run) begin
      if (period_hit) begin
        d.cnt = HCL_WORD_RST;
      end else begin
        d.cnt = q.cnt + 16'h0001;
      end
    end
    if (period_hit && !hall) begin
      // Normal shadow transfer, suppressed in Hall mode
      d.per  = q.per_sh;  // [R12]
      d.cmp1 = q.cmp1_sh; // [R12]
      d.cmp2 = q.cmp2_sh;
      d.psl  = q.psl_sh;  // [R12]
    end
    if (correct_event_flag) begin
      d.current_hall_pattern = q.curhs;
      d.expected_hall_pattern = q.exphs;
    end
    if (hall && correct_event_flag) begin
      d.cap  = q.cnt;          // [R08] [R10]
      d.cnt  = HCL_WORD_RST;   // [R10]
      d.per  = q.per_sh;       // [R11]
      d.cmp1 = q.cmp1_sh;      // [R09]
      d.cmp2 = q.cmp2_sh;      // [R09]
    end

    // ********************************
    // Register writes
    // ********************************
    multichannel_shadow_transfer = ((q.switch_enable_select == HCL_SW_CHE) && correct_event_flag)
          || ((q.switch_enable_select == HCL_SW_CMP1) && match1); // [R13]
    if (wr_ok) begin
      if (i_addr == HCL_MODE_OFS) begin
        d.mode = i_wdata[11:0];
      end else if (i_addr == HCL_CTRL_OFS) begin
        d.run     = i_wdata[HCL_CTRL_RUN];
        d.idle_en = i_wdata[HCL_CTRL_IDLEEN];
        d.switch_enable_select    = i_wdata[HCL_CTRL_SWITCH_ENABLE_SELECT+1:HCL_CTRL_SWITCH_ENABLE_SELECT];
      end else if (i_addr == HCL_DTREL_OFS) begin
        d.dt_rel = i_wdata[7:0];
      end else if (i_addr == HCL_PERIOD_OFS) begin
        d.per_sh = i_wdata;
        if (!q.run) begin
          d.per = i_wdata; // [R12]
        end
      end else if (i_addr == HCL_CMP1_OFS) begin
        d.cmp1_sh = i_wdata;
        if (!q.run) begin
          d.cmp1 = i_wdata; // [R12]
        end
      end else if (i_addr == HCL_CMP2_OFS) begin
        d.cmp2_sh = i_wdata;
        if (!q.run) begin
          d.cmp2 = i_wdata; // [R12]
        end
      end else if (i_addr == HCL_PATSH_OFS) begin
        d.curhs = i_wdata[HCL_PAT_CURRENT_HALL_PATTERN+2:HCL_PAT_CURRENT_HALL_PATTERN];
        d.exphs = i_wdata[HCL_PAT_EXPECTED_HALL_PATTERN+2:HCL_PAT_EXPECTED_HALL_PATTERN];
        d.mcmps = i_wdata[5:0];
        if (i_wdata[HCL_PAT_HALLREQ]) begin
          d.current_hall_pattern = i_wdata[HCL_PAT_CURRENT_HALL_PATTERN+2:HCL_PAT_CURRENT_HALL_PATTERN]; // [R24]
          d.expected_hall_pattern = i_wdata[HCL_PAT_EXPECTED_HALL_PATTERN+2:HCL_PAT_EXPECTED_HALL_PATTERN]; // [R24]
        end
        if (i_wdata[HCL_PAT_MCMREQ]) begin
          multichannel_shadow_transfer = 1'b1;
        end
      end else if (i_addr == HCL_STSET_OFS) begin
        sw_set = i_wdata[4:0]; // [R16] [R21]
      end else if (i_addr == HCL_STCLR_OFS) begin
        sw_clr = i_wdata[4:0]; // [R17]
      end else if (i_addr == HCL_IEN_OFS) begin
        d.interrupt_enable_register = i_wdata[4:0];
      end else if (i_addr == HCL_PASSIVE_OFS) begin
        d.psl_sh = i_wdata[5:0];
        if (!q.run) begin
          d.psl = i_wdata[5:0]; // [R12]
        end
      end
    end

    // The written shadow value goes straight through on a software request
    if (multichannel_shadow_transfer) begin
      d.mcmps = (wr_ok && (i_addr == HCL_PATSH_OFS)) ? i_wdata[5:0] : q.mcmps;
      d.multichannel_output_pattern  = d.mcmps; // [R13]
    end

    // ********************************
    // Flags and interrupt request
    // ********************************
    hw_set = 5'h00;
    hw_set[HCL_F_CHE]  = correct_event_flag;                 // [R16]
    hw_set[HCL_F_WHE]  = wrong_event_flag;                 // [R18]
    hw_set[HCL_F_STR]  = multichannel_shadow_transfer;              // [R19]
    hw_set[HCL_F_IDLE] = wrong_event_flag && q.idle_en;    // [R21]
    hw_set[HCL_F_TMO]  = match2;              // [R14]
    // Set wins over a clear in the same cycle
    d.flags = (q.flags & ~sw_clr) | sw_set | hw_set; // [R17] [R18] [R19]
    // Every set event except idle requests, whatever the flag already holds
    d.irq = |((hw_set | sw_set) & q.interrupt_enable_register & HCL_IRQ_MASK); // [R16] [R20]
    if (d.flags[HCL_F_IDLE]) begin
      d.multichannel_output_pattern = 6'h00; // [R22]
    end

    // ********************************
    // Read data, valid one cycle after the strobe only
    // ********************************
    d.rdata = HCL_WORD_RST;
    if (i_rd) begin
      if (i_addr == HCL_MODE_OFS) begin
        d.rdata = {4'h0, q.mode};
      end else if (i_addr == HCL_CTRL_OFS) begin
        d.rdata = {12'h000, q.switch_enable_select, q.idle_en, q.run};
      end else if (i_addr == HCL_DTREL_OFS) begin
        d.rdata = {8'h00, q.dt_rel};
      end else if (i_addr == HCL_PERIOD_OFS) begin
        d.rdata = q.per;
      end else if (i_addr == HCL_CMP1_OFS) begin
        d.rdata = q.cmp1;
      end else if (i_addr == HCL_CMP2_OFS) begin
        d.rdata = q.cmp2;
      end else if (i_addr == HCL_CAPT_OFS) begin
        d.rdata = q.cap;
      end else if (i_addr == HCL_COUNT_OFS) begin
        d.rdata = q.cnt;
      end else if (i_addr == HCL_PATSH_OFS) begin
        d.rdata = {2'h0, q.curhs, q.exphs, 2'h0, q.mcmps};
      end else if (i_addr == HCL_PATACT_OFS) begin
        d.rdata = {2'h0, q.current_hall_pattern, q.expected_hall_pattern, 2'h0, q.multichannel_output_pattern};
      end else if (i_addr == HCL_STAT_OFS) begin
        d.rdata = {11'h000, q.flags};
      end else if (i_addr == HCL_IEN_OFS) begin
        d.rdata = {11'h000, q.interrupt_enable_register};
      end else if (i_addr == HCL_PASSIVE_OFS) begin
        d.rdata = {10'h000, q.psl};
      end
    end
  end

  // ********************************
  // State register
  // ********************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q        <= '0;
      q.mode   <= HCL_MODE_RST;
      q.dt_rel <= HCL_DTREL_RST;
    end else begin
      q <= d;
    end
  end

  assign o_rdata                       = q.rdata;
  assign o_multichannel_output_pattern = q.multichannel_output_pattern;
  assign o_passive_level_bits          = q.psl;
  assign o_correct_hall_event          = q.che_p;
  assign o_wrong_hall_event            = q.whe_p;
  assign o_irq                         = q.irq;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  chk_sync_chain: assert property ( // [R25]
    ##1 q.sync2 == $past(q.sync1))
    else $error("sync second stage wrong");

  chk_edge_reload: assert property ( // [R01] [R03]
    edge_det |=> q.dtc == $past(q.dt_rel))
    else $error("edge did not reload dead-time counter");

  chk_ready_count: assert property ( // [R04]
    (q.dtc == 8'h02) && !edge_det ##1 !edge_det |-> ready)
    else $error("compare ready not at count one");

  chk_noise_quiet: assert property ( // [R05]
    ready && (q.sync2 == q.current_hall_pattern) |=> !o_correct_hall_event && !o_wrong_hall_event)
    else $error("event on noise spike");

  chk_correct_pulse: assert property ( // [R06]
    ready && (q.sync2 == q.expected_hall_pattern) && (q.sync2 != q.current_hall_pattern)
      |=> o_correct_hall_event ##1 !o_correct_hall_event)
    else $error("correct event not one pulse");

  chk_wrong_pulse: assert property ( // [R07]
    wrong_event_flag |=> o_wrong_hall_event && q.flags[HCL_F_WHE])
    else $error("wrong event or flag missing");

  chk_capture_reset: assert property ( // [R10] [R11]
    hall && correct_event_flag |=> q.cap == $past(q.cnt) && q.cnt == 16'h0000
      && q.per == $past(q.per_sh))
    else $error("capture or period load missing");

  chk_flag_hold: assert property ( // [R17]
    q.flags[HCL_F_CHE] && !(i_wr && (i_addr == HCL_STCLR_OFS) && i_wdata[HCL_F_CHE])
      |=> q.flags[HCL_F_CHE])
    else $error("correct flag lost without clear");

  chk_irq_rearm: assert property ( // [R20]
    correct_event_flag && q.interrupt_enable_register[HCL_F_CHE] |=> o_irq)
    else $error("set event gave no request");

  chk_idle_clear: assert property ( // [R22]
    q.flags[HCL_F_IDLE] |-> o_multichannel_output_pattern == 6'h00)
    else $error("pattern not cleared in idle");

  chk_hall_request: assert property ( // [R24]
    i_wr && (i_addr == HCL_PATSH_OFS) && i_wdata[HCL_PAT_HALLREQ] && !correct_event_flag
      |=> q.current_hall_pattern == $past(i_wdata[13:11]) && q.expected_hall_pattern == $past(i_wdata[10:8]))
    else $error("hall request did not copy patterns");

  // ********************************
  // Assertions on timer, transfers and flags
  // ********************************
  chk_dtc_count: assert property ( // [R03]
    !edge_det && (q.dtc != 8'h00) |=> q.dtc == $past(q.dtc) - 8'h01)
    else $error("dead-time counter did not count down");

  chk_noise_hold: assert property ( // [R05]
    ready && (q.sync2 == q.current_hall_pattern) && !i_wr |=> q.cap == $past(q.cap) && q.current_hall_pattern == $past(q.current_hall_pattern))
    else $error("noise spike moved capture or pattern");

  // Writes are left out: a stopped write may override the copy
  chk_shadow_compare: assert property ( // [R09]
    hall && correct_event_flag && !i_wr |=> q.cmp1 == $past(q.cmp1_sh) && q.cmp2 == $past(q.cmp2_sh))
    else $error("compare shadows not copied on correct event");

  chk_no_shadow_xfer: assert property ( // [R12]
    hall && period_hit && !i_wr |=> q.psl == $past(q.psl))
    else $error("passive levels moved in Hall mode");

  chk_stopped_write: assert property ( // [R12]
    i_wr && (i_addr == HCL_PASSIVE_OFS) && !q.run |=> q.psl == $past(i_wdata[5:0]))
    else $error("stopped write missed the active register");

  chk_phase_delay: assert property ( // [R13]
    match1 && (q.switch_enable_select == HCL_SW_CMP1) |=> q.flags[HCL_F_STR])
    else $error("channel 1 match gave no pattern transfer");

  chk_timeout_flag: assert property ( // [R14]
    match2 |=> q.flags[HCL_F_TMO])
    else $error("channel 2 match did not set time-out flag");

  chk_timeout_irq: assert property ( // [R14]
    match2 && q.interrupt_enable_register[HCL_F_TMO] |=> o_irq)
    else $error("time-out gave no request");

  chk_sw_set: assert property ( // [R16]
    i_wr && (i_addr == HCL_STSET_OFS) && i_wdata[HCL_F_CHE] |=> q.flags[HCL_F_CHE])
    else $error("software set of correct flag lost");

  chk_flag_clear: assert property ( // [R17]
    i_wr && (i_addr == HCL_STCLR_OFS) && i_wdata[HCL_F_CHE] && !correct_event_flag
      |=> !q.flags[HCL_F_CHE])
    else $error("software clear of correct flag lost");

  chk_wrong_hold: assert property ( // [R18]
    q.flags[HCL_F_WHE] && !(i_wr && (i_addr == HCL_STCLR_OFS) && i_wdata[HCL_F_WHE])
      |=> q.flags[HCL_F_WHE])
    else $error("wrong flag lost without clear");

  chk_wrong_irq: assert property ( // [R18] [R20]
    wrong_event_flag && q.interrupt_enable_register[HCL_F_WHE] |=> o_irq)
    else $error("wrong event gave no request");

  chk_transfer_flag: assert property ( // [R19]
    multichannel_shadow_transfer |=> q.flags[HCL_F_STR])
    else $error("pattern transfer did not set its flag");

  chk_transfer_irq: assert property ( // [R19] [R20]
    multichannel_shadow_transfer && q.interrupt_enable_register[HCL_F_STR] |=> o_irq)
    else $error("pattern transfer gave no request");

  chk_idle_set: assert property ( // [R21]
    wrong_event_flag && q.idle_en |=> q.flags[HCL_F_IDLE])
    else $error("wrong event did not enter idle");

  chk_idle_quiet: assert property ( // [R21]
    !q.flags[HCL_F_IDLE] && !(wrong_event_flag && q.idle_en)
      && !(i_wr && (i_addr == HCL_STSET_OFS) && i_wdata[HCL_F_IDLE])
      |=> !q.flags[HCL_F_IDLE])
    else $error("idle flag set without cause");

  cov_correct: cover property (hall && correct_event_flag);
  cov_wrong_idle: cover property (wrong_event_flag && q.idle_en);
  cov_phase_delay: cover property (match1 && (q.switch_enable_select == HCL_SW_CMP1));
  cov_timeout: cover property (match2 && q.interrupt_enable_register[HCL_F_TMO]);
  cov_sw_restart: cover property (
    i_wr && (i_addr == HCL_PATSH_OFS) && i_wdata[HCL_PAT_HALLREQ]);

endmodule

/* test/hcl_hall_sensor_model.sv */
// Behavioural trio of Hall sensors feeding the position inputs.
// Assumes the bench calls its tasks from the block's clock domain.
`timescale 1ns/10ps
module hcl_hall_sensor_model (
  // Clock
  input  wire logic       i_clk,
  // Sensor lines
  output logic      [2:0] o_hall
);
  // Push-pull sensors: a level always stands between moves
  initial o_hall = 3'h0;

  task automatic move(input logic [2:0] pat);
    @(posedge i_clk);
    o_hall <= pat;
  endtask

  // One-cycle glitch, short enough to be gone when the filter samples
  task automatic spike(input logic [2:0] pat);
    logic [2:0] keep;
    keep = o_hall;
    @(posedge i_clk);
    o_hall <= pat;
    @(posedge i_clk);
    o_hall <= keep;
  endtask
endmodule

/* test/tb_hall_commutation_logic.sv */
// Self-checking bench for the Hall commutation logic.
// Assumes the sensor model drives the position inputs; the bench owns the register port.
`timescale 1ns/10ps
module tb_hall_commutation_logic
  import hcl_pkg::*;
;
  logic        i_clk     = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [7:0]  i_addr    = 8'h00;
  logic [15:0] i_wdata   = 16'h0000;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic [15:0] o_rdata;
  logic [2:0]  hall;
  logic [5:0]  o_pat;
  logic [5:0]  o_psl;
  logic        o_che;
  logic        o_whe;
  logic        o_irq;
  int          num_errors      = 0;
  int          samples_checked = 0;
  int          che_cnt         = 0;
  int          whe_cnt         = 0;
  int          irq_cnt         = 0;
  localparam int RELOAD = 3;

  always #2 i_clk = ~i_clk;

  hcl_hall_sensor_model sens (.i_clk(i_clk), .o_hall(hall));

  hcl_hall_logic dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_hall_position_input(hall),
    .o_multichannel_output_pattern(o_pat), .o_passive_level_bits(o_psl),
    .o_correct_hall_event(o_che), .o_wrong_hall_event(o_whe), .o_irq(o_irq)
  );

  // Pulse counters: single-cycle outputs are easy to miss from a task
  always @(posedge i_clk) begin
    if (o_che === 1'b1) che_cnt <= che_cnt + 1;
    if (o_whe === 1'b1) whe_cnt <= whe_cnt + 1;
    if (o_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] msk, input logic [15:0] exp,
                     input string m);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    check(o_rdata & msk, exp, m);
  endtask

  task automatic settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask

  task automatic final_report();
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_regs();
    rdc(HCL_DTREL_OFS, 16'hFFFF, 16'h0001, "reload reset");
    rdc(HCL_STAT_OFS, 16'hFFFF, 16'h0000, "status reset");
    rdc(HCL_STSET_OFS, 16'hFFFF, 16'h0000, "write-only reads zero");
    rdc(8'h1E, 16'hFFFF, 16'h0000, "unmapped reads zero");
    check({10'h000, o_pat}, 16'h0000, "pattern reset");
  endtask

  task automatic t_setup();
    // The block has no timer modulation path, so none is left to clear
    wr(HCL_MODE_OFS, 16'h0888);
    wr(HCL_DTREL_OFS, 16'h0003);
    wr(HCL_PERIOD_OFS, 16'h0100);
    wr(HCL_CMP1_OFS, 16'h0020);
    wr(HCL_CMP2_OFS, 16'h0040);
    wr(HCL_IEN_OFS, 16'h0001);
    rdc(HCL_PERIOD_OFS, 16'hFFFF, 16'h0100, "stopped write");
    wr(HCL_PASSIVE_OFS, 16'h0015);
    rdc(HCL_PASSIVE_OFS, 16'hFFFF, 16'h0015, "passive stopped write");
    check({10'h000, o_psl}, 16'h0015, "passive levels out");
    wr(HCL_PATSH_OFS, 16'h8195);
    rdc(HCL_PATACT_OFS, 16'hFFFF, 16'h0115, "hall request copy");
    rdc(HCL_PATSH_OFS, 16'h8080, 16'h0000, "request bits read zero");
    check({10'h000, o_pat}, 16'h0015, "pattern request");
    wr(HCL_CTRL_OFS, 16'h0001);
    wr(HCL_PERIOD_OFS, 16'h0300);
    wr(HCL_CMP1_OFS, 16'h0030);
    rdc(HCL_PERIOD_OFS, 16'hFFFF, 16'h0100, "period held in shadow");
    wr(HCL_PATSH_OFS, 16'h0B15);
  endtask

  task automatic t_correct();
    int c0;
    int i0;
    int n;
    c0 = che_cnt;
    i0 = irq_cnt;
    n  = 0;
    sens.move(3'h1);
    while (che_cnt == c0 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    check(16'(n >= RELOAD + 1 && n <= RELOAD + 7), 16'h0001, "sample delay");
    check(16'(che_cnt - c0), 16'h0001, "one correct pulse");
    check(16'(irq_cnt - i0), 16'h0001, "correct irq");
    rdc(HCL_COUNT_OFS, 16'hFFC0, 16'h0000, "timer reset");
    // Timer ran fourteen cycles from its start to the sample
    rdc(HCL_CAPT_OFS, 16'hFFFF, 16'h000E, "capture taken");
    rdc(HCL_PERIOD_OFS, 16'hFFFF, 16'h0300, "period loaded");
    rdc(HCL_CMP1_OFS, 16'hFFFF, 16'h0030, "compare shadow copy");
    rdc(HCL_PATACT_OFS, 16'h3F00, 16'h0B00, "hall shadow copy");
    rdc(HCL_STAT_OFS, 16'h0001, 16'h0001, "correct flag");
    wr(HCL_CTRL_OFS, 16'h000B);
    wr(HCL_PATSH_OFS, 16'h0B2A);
    // Transfer flag is still set from the setup request
    wr(HCL_STCLR_OFS, 16'h0004);
    repeat (40) @(posedge i_clk);
    #1;
    check({10'h000, o_pat}, 16'h002A, "channel 1 transfer");
    rdc(HCL_STAT_OFS, 16'h0004, 16'h0004, "transfer flag");
    repeat (40) @(posedge i_clk);
    rdc(HCL_STAT_OFS, 16'h0010, 16'h0010, "time-out flag");
    wr(HCL_PASSIVE_OFS, 16'h002A);
    settle();
    check({10'h000, o_psl}, 16'h0015, "passive held in shadow");
  endtask

  task automatic t_spike();
    int e0;
    e0 = che_cnt + whe_cnt;
    sens.spike(3'h0);
    repeat (20) @(posedge i_clk);
    check(16'(che_cnt + whe_cnt - e0), 16'h0000, "spike filtered");
  endtask

  task automatic t_wrong();
    int w0;
    w0 = whe_cnt;
    sens.move(3'h6);
    repeat (20) @(posedge i_clk);
    check(16'(whe_cnt - w0), 16'h0001, "wrong pulse");
    rdc(HCL_STAT_OFS, 16'h000B, 16'h000B, "wrong and idle flags");
    check({10'h000, o_pat}, 16'h0000, "idle clears pattern");
  endtask

  task automatic t_flags();
    int i0;
    wr(HCL_STCLR_OFS, 16'h0001);
    rdc(HCL_STAT_OFS, 16'h0001, 16'h0000, "software clear");
    i0 = irq_cnt;
    wr(HCL_STSET_OFS, 16'h0001);
    wr(HCL_STSET_OFS, 16'h0001);
    settle();
    check(16'(irq_cnt - i0), 16'h0002, "irq per set event");
    rdc(HCL_STAT_OFS, 16'h0001, 16'h0001, "software set");
  endtask

  task automatic t_restart();
    wr(HCL_STCLR_OFS, 16'h0008);
    wr(HCL_PATSH_OFS, 16'hB4AA);
    settle();
    check({10'h000, o_pat}, 16'h002A, "pattern after idle");
    rdc(HCL_PATACT_OFS, 16'h3F3F, 16'h342A, "restart copy");
    wr(HCL_CTRL_OFS, 16'h0005);
    wr(HCL_PATSH_OFS, 16'h2015);
    sens.move(3'h4);
    repeat (20) @(posedge i_clk);
    #1;
    check({10'h000, o_pat}, 16'h0015, "correct event transfer");
    wr(HCL_STSET_OFS, 16'h0008);
    settle();
    check({10'h000, o_pat}, 16'h0000, "software idle clears pattern");
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_reset_regs();
    t_setup();
    t_correct();
    t_spike();
    t_wrong();
    t_flags();
    t_restart();
    final_report();
  end

  // Whole run is under a thousand cycles; twenty thousand marks a hang
  initial begin
    #(4 * 20000);
    num_errors++;
    final_report();
  end
endmodule
